// ### rtl/tcp_cfg.svh
// Purpose: Offsets, field positions and resets of the PWM block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef TCP_CFG_SVH
`define TCP_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TCP_A_CTRL  8'h00
`define TCP_A_STAT  8'h04
`define TCP_A_UCMP  8'h08
`define TCP_A_UBUF  8'h0C
`define TCP_A_CMP1  8'h10
`define TCP_A_BUF1  8'h14
`define TCP_A_CMP2  8'h18
`define TCP_A_BUF2  8'h1C
`define TCP_A_CMP3  8'h20
`define TCP_A_BUF3  8'h24
`define TCP_A_LEAD  8'h28
`define TCP_A_LAG   8'h2C
`define TCP_A_DEAD  8'h30
`define TCP_A_HALF  8'h34
`define TCP_A_HBUF  8'h38
// ----------------------------------------
// Control and status bit positions
// ----------------------------------------
`define TCP_C_START 0
`define TCP_C_BYP   1
`define TCP_C_TOG   2
`define TCP_C_PLVL  3
`define TCP_C_ALVL  4
`define TCP_C_XTR   5
`define TCP_C_SKPL  8
`define TCP_C_SKPH  11
`define TCP_S_PEAK  0
`define TCP_S_TRGH  1
// ----------------------------------------
// Reset values
// ----------------------------------------
`define TCP_R_CTRL  16'h0000
`define TCP_R_REG   16'h0000
`define TCP_R_UPPER 16'hFFFF
`endif

// ### rtl/tcp_pkg.sv
// Purpose: Types shared by the PWM block and its bench
// Assumes: Constants come from tcp_cfg.svh
// Notes:   Carrier structs for the APB side and the pins
package tcp_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } tcp_mode_e;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tcp_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tcp_apb_rsp_t;
  typedef struct packed {
    logic [2:0] pos;
    logic [2:0] anti;
    logic       tog;
    logic       adc;
    logic       peak;
    logic       trough;
  } tcp_pwm_t;
  typedef logic [2:0][15:0] tcp_trio_t;
  typedef struct packed {
    tcp_mode_e    mode;
    logic [15:0]  ctrl;
    logic [15:0]  c3;
    logic [15:0]  c4;
    logic         dn3;
    logic         dn4;
    logic [15:0]  upper;
    logic [15:0]  ubuf;
    tcp_trio_t    cmp;
    tcp_trio_t    buff;
    tcp_trio_t    stg;
    logic         pend;
    logic [15:0]  dead;
    logic [15:0]  half;
    logic [15:0]  hbuf;
    logic         pk_f;
    logic         tr_f;
    logic [3:0]   skip;
    tcp_apb_rsp_t rsp;
    tcp_pwm_t     pwm;
  } tcp_state_t;
endpackage

// ### rtl/tcp_pwm.sv
// Purpose: Three-phase complementary PWM with dead time
// Assumes: APB slave, zero wait, one counter step per clock
// Notes:   Outputs come straight from the state register
//
// Overview of operation
// - Three phases, each a positive and an antiphase output: six lines.
// - Dead-time gap keeps each pair apart; a control bit drops it.
// - Optional toggle pin switching in step with the carrier.
// - Upper limit is the lead counter turning point: half period plus dead.
// - Each duty compare sets one phase through compare against the lead counter.
// - Upper limit and duties each have a buffer copied in while running.
// - Duties move buffer to hidden staging, then staging to compare.
// - Staging registers are neither readable nor writable by software.
// - 16-bit lead counter turns down at upper limit, up at dead time.
// - 16-bit lag counter turns down at half cycle, up at zero.
// - 16-bit dead-time register sets the gap for all pairs.
// - 16-bit half-cycle register sets the lag counter turning point.
// - Half-cycle register is reloaded from its buffer while running.
// - Peak and trough events; converter triggers can be skipped.
// - Start loads lead with dead time, lag with zero, both together.
// - Phase-three buffer write, written last, triggers the staging move.
// - Duty zero forces 0%/100%; duty at or above upper forces 100%/0%.
// - Positive and antiphase active levels chosen by separate bits.
`timescale 1ns/10ps
`include "tcp_cfg.svh"
module tcp_pwm (
  input  wire logic                  clock_i,
  input  wire logic                  rst_b_i,
  input  wire tcp_pkg::tcp_apb_req_t apb_i,
  output tcp_pkg::tcp_apb_rsp_t      apb_o,
  output tcp_pkg::tcp_pwm_t          pwm_o
);
  import tcp_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Returns {positive active, antiphase active}
  function automatic logic [1:0] phase_act(
    input logic [15:0] duty,
    input logic [15:0] c3,
    input logic [15:0] upper,
    input logic [15:0] dead,
    input logic        byp
  );
    logic [16:0] edge_hi;
    logic        p;
    logic        a;
    edge_hi = {1'b0, duty} + {1'b0, dead};
    p = (c3 < duty);
    a = byp ? (c3 >= duty) : ({1'b0, c3} > edge_hi);
    if (duty == 16'h0000) begin
      phase_act = 2'b01;
    end else if (duty >= upper) begin
      phase_act = 2'b10;
    end else begin
      phase_act = {p, a};
    end
  endfunction

  // Active level bit 1 means active high
  function automatic logic drive(
    input logic act,
    input logic lvl
  );
    drive = ~(act ^ lvl);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  tcp_state_t s_q;
  tcp_state_t s_d;
  logic       run;
  logic       pk;
  logic       tr;
  logic       acc;
  logic       wr;
  logic       xfer;
  logic [1:0] act0;
  logic [1:0] act1;
  logic [1:0] act2;

  assign run  = (s_q.mode == ST_RUN);
  assign pk   = run & ~s_q.dn3 & (s_q.c3 == s_q.upper);
  assign tr   = run & s_q.dn4 & (s_q.c4 == 16'h0000);
  assign acc  = apb_i.psel & apb_i.penable & s_q.rsp.pready;
  assign wr   = acc & apb_i.pwrite;
  // Trough transfer doubles the update rate at no extra cost
  assign xfer = pk | (tr & s_q.ctrl[`TCP_C_XTR]);
  assign act0 = phase_act(s_q.cmp[0], s_q.c3, s_q.upper, s_q.dead,
                          s_q.ctrl[`TCP_C_BYP]);
  assign act1 = phase_act(s_q.cmp[1], s_q.c3, s_q.upper, s_q.dead,
                          s_q.ctrl[`TCP_C_BYP]);
  assign act2 = phase_act(s_q.cmp[2], s_q.c3, s_q.upper, s_q.dead,
                          s_q.ctrl[`TCP_C_BYP]);

  always_comb begin
    s_d = s_q;
    s_d.pwm.adc    = 1'b0;
    s_d.pwm.peak   = pk;
    s_d.pwm.trough = tr;
    // ----------------------------------------
    // Counters
    // ----------------------------------------
    case (s_q.mode)
      ST_IDLE: begin
        if (s_q.ctrl[`TCP_C_START]) begin
          s_d.mode    = ST_RUN;
          s_d.c3      = s_q.dead;
          s_d.c4      = 16'h0000;
          s_d.dn3     = 1'b0;
          s_d.dn4     = 1'b0;
          s_d.pwm.tog = 1'b0;
          s_d.skip    = 4'h0;
        end
      end
      ST_RUN: begin
        if (!s_q.ctrl[`TCP_C_START]) begin
          s_d.mode = ST_IDLE;
        end else begin
          if (pk) begin
            s_d.dn3 = 1'b1;
            s_d.c3  = s_q.c3 - 16'h0001;
          end else if (s_q.dn3 && s_q.c3 == s_q.dead) begin
            s_d.dn3 = 1'b0;
            s_d.c3  = s_q.c3 + 16'h0001;
          end else begin
            s_d.c3 = s_q.dn3 ? s_q.c3 - 16'h0001 : s_q.c3 + 16'h0001;
          end
          if (!s_q.dn4 && s_q.c4 == s_q.half) begin
            s_d.dn4 = 1'b1;
            s_d.c4  = s_q.c4 - 16'h0001;
          end else if (tr) begin
            s_d.dn4 = 1'b0;
            s_d.c4  = s_q.c4 + 16'h0001;
          end else begin
            s_d.c4 = s_q.dn4 ? s_q.c4 - 16'h0001 : s_q.c4 + 16'h0001;
          end
          if ((pk || tr) && s_q.ctrl[`TCP_C_TOG]) begin
            s_d.pwm.tog = ~s_q.pwm.tog;
          end
          if (tr) begin
            // Fire on every (skip+1)th trough
            if (s_q.skip == s_q.ctrl[`TCP_C_SKPH:`TCP_C_SKPL]) begin
              s_d.pwm.adc = 1'b1;
              s_d.skip    = 4'h0;
            end else begin
              s_d.skip = s_q.skip + 4'h1;
            end
          end
        end
      end
      default: begin
        s_d.mode = ST_IDLE;
      end
    endcase
    // ----------------------------------------
    // Buffered transfers
    // ----------------------------------------
    if (xfer) begin
      s_d.upper = s_q.ubuf;
      s_d.half  = s_q.hbuf;
      if (s_q.pend) begin
        s_d.cmp  = s_q.stg;
        s_d.pend = 1'b0;
      end
    end
    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    if (wr) begin
      case (apb_i.paddr)
        `TCP_A_CTRL: s_d.ctrl = apb_i.pwdata[15:0];
        `TCP_A_STAT: begin
          if (apb_i.pwdata[`TCP_S_PEAK]) s_d.pk_f = 1'b0;
          if (apb_i.pwdata[`TCP_S_TRGH]) s_d.tr_f = 1'b0;
        end
        `TCP_A_UCMP: if (!run) s_d.upper = apb_i.pwdata[15:0];
        `TCP_A_UBUF: s_d.ubuf = apb_i.pwdata[15:0];
        `TCP_A_CMP1: if (!run) s_d.cmp[0] = apb_i.pwdata[15:0];
        `TCP_A_BUF1: s_d.buff[0] = apb_i.pwdata[15:0];
        `TCP_A_CMP2: if (!run) s_d.cmp[1] = apb_i.pwdata[15:0];
        `TCP_A_BUF2: s_d.buff[1] = apb_i.pwdata[15:0];
        `TCP_A_CMP3: if (!run) s_d.cmp[2] = apb_i.pwdata[15:0];
        `TCP_A_BUF3: begin
          s_d.buff[2] = apb_i.pwdata[15:0];
          s_d.stg     = {apb_i.pwdata[15:0], s_q.buff[1], s_q.buff[0]};
          s_d.pend    = 1'b1;
        end
        `TCP_A_LEAD: if (!run) s_d.c3 = apb_i.pwdata[15:0];
        `TCP_A_LAG:  if (!run) s_d.c4 = apb_i.pwdata[15:0];
        `TCP_A_DEAD: s_d.dead = apb_i.pwdata[15:0];
        `TCP_A_HALF: if (!run) s_d.half = apb_i.pwdata[15:0];
        `TCP_A_HBUF: s_d.hbuf = apb_i.pwdata[15:0];
        default: begin
        end
      endcase
    end
    // Set after clear, so a same-cycle event survives
    if (pk) s_d.pk_f = 1'b1;
    if (tr) s_d.tr_f = 1'b1;
    // ----------------------------------------
    // Read side, latched in the setup cycle
    // ----------------------------------------
    s_d.rsp.pready  = apb_i.psel & ~apb_i.penable;
    s_d.rsp.pslverr = 1'b0;
    s_d.rsp.prdata  = 32'h0000_0000;
    if (apb_i.psel && !apb_i.penable) begin
      // Staging holds no address, so it never reads back
      case (apb_i.paddr)
        `TCP_A_CTRL: s_d.rsp.prdata = {16'h0000, s_q.ctrl};
        `TCP_A_STAT: s_d.rsp.prdata = {27'h0, s_q.pend, run, s_q.dn3,
                                       s_q.tr_f, s_q.pk_f};
        `TCP_A_UCMP: s_d.rsp.prdata = {16'h0000, s_q.upper};
        `TCP_A_UBUF: s_d.rsp.prdata = {16'h0000, s_q.ubuf};
        `TCP_A_CMP1: s_d.rsp.prdata = {16'h0000, s_q.cmp[0]};
        `TCP_A_BUF1: s_d.rsp.prdata = {16'h0000, s_q.buff[0]};
        `TCP_A_CMP2: s_d.rsp.prdata = {16'h0000, s_q.cmp[1]};
        `TCP_A_BUF2: s_d.rsp.prdata = {16'h0000, s_q.buff[1]};
        `TCP_A_CMP3: s_d.rsp.prdata = {16'h0000, s_q.cmp[2]};
        `TCP_A_BUF3: s_d.rsp.prdata = {16'h0000, s_q.buff[2]};
        `TCP_A_LEAD: s_d.rsp.prdata = {16'h0000, s_q.c3};
        `TCP_A_LAG:  s_d.rsp.prdata = {16'h0000, s_q.c4};
        `TCP_A_DEAD: s_d.rsp.prdata = {16'h0000, s_q.dead};
        `TCP_A_HALF: s_d.rsp.prdata = {16'h0000, s_q.half};
        `TCP_A_HBUF: s_d.rsp.prdata = {16'h0000, s_q.hbuf};
        default:     s_d.rsp.pslverr = 1'b1;
      endcase
    end
    // ----------------------------------------
    // Pins
    // ----------------------------------------
    // Stopped: all six lines parked at their inactive level
    s_d.pwm.pos[0]  = drive(run & act0[1], s_q.ctrl[`TCP_C_PLVL]);
    s_d.pwm.anti[0] = drive(run & act0[0], s_q.ctrl[`TCP_C_ALVL]);
    s_d.pwm.pos[1]  = drive(run & act1[1], s_q.ctrl[`TCP_C_PLVL]);
    s_d.pwm.anti[1] = drive(run & act1[0], s_q.ctrl[`TCP_C_ALVL]);
    s_d.pwm.pos[2]  = drive(run & act2[1], s_q.ctrl[`TCP_C_PLVL]);
    s_d.pwm.anti[2] = drive(run & act2[0], s_q.ctrl[`TCP_C_ALVL]);
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q           <= '0;
      s_q.mode      <= ST_IDLE;
      s_q.ctrl      <= `TCP_R_CTRL;
      s_q.upper     <= `TCP_R_UPPER;
      s_q.ubuf      <= `TCP_R_UPPER;
      s_q.dead      <= `TCP_R_REG;
      s_q.half      <= `TCP_R_REG;
      s_q.hbuf      <= `TCP_R_REG;
      s_q.pwm.pos   <= 3'h7;
      s_q.pwm.anti  <= 3'h7;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_o = s_q.rsp;
  assign pwm_o = s_q.pwm;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  logic [2:0] pa_w;
  logic [2:0] aa_w;
  assign pa_w = ~(s_q.pwm.pos ^ {3{s_q.ctrl[`TCP_C_PLVL]}});
  assign aa_w = ~(s_q.pwm.anti ^ {3{s_q.ctrl[`TCP_C_ALVL]}});

  a_pair_no_overlap: assert property (
    run && $stable(s_q.ctrl) && !s_q.ctrl[`TCP_C_BYP] |-> (pa_w & aa_w) == 3'h0)
    else $error("positive and antiphase active together");
  a_lead_turn_down: assert property (
    pk && s_q.ctrl[`TCP_C_START] |=> s_q.dn3 && s_q.c3 == $past(s_q.c3) - 16'h0001)
    else $error("lead counter did not turn down at peak");
  a_lag_turn_up: assert property (
    tr && s_q.ctrl[`TCP_C_START] |=> !s_q.dn4 && s_q.c4 == 16'h0001)
    else $error("lag counter did not turn up at zero");
  a_start_load: assert property (
    !run && s_q.ctrl[`TCP_C_START] |=> run && s_q.c4 == 16'h0000
      && s_q.c3 == $past(s_q.dead) && !s_q.pwm.tog)
    else $error("start did not load counters");
  a_upper_from_buf: assert property (
    pk && !wr |=> s_q.upper == $past(s_q.ubuf) && s_q.half == $past(s_q.hbuf))
    else $error("limits not reloaded at peak");
  a_stage_load: assert property (
    wr && apb_i.paddr == `TCP_A_BUF3 |=> s_q.pend
      && s_q.stg[2] == $past(apb_i.pwdata[15:0]))
    else $error("phase three write did not stage");
  a_stage_to_cmp: assert property (
    pk && s_q.pend && !wr |=> !s_q.pend && s_q.cmp == $past(s_q.stg))
    else $error("staged duties not moved at peak");
  // A control write in the same cycle changes the level select under the pins
  a_zero_duty: assert property (
    run && s_q.cmp[0] == 16'h0000 && !(wr && apb_i.paddr == `TCP_A_CTRL)
      |=> !pa_w[0] && aa_w[0])
    else $error("zero duty not forced");
  a_lead_turn_up: assert property (
    run && s_q.ctrl[`TCP_C_START] && s_q.dn3 && s_q.c3 == s_q.dead && !pk
      |=> !s_q.dn3)
    else $error("lead counter did not turn up at dead time");
  a_lag_turn_down: assert property (
    run && s_q.ctrl[`TCP_C_START] && !s_q.dn4 && s_q.c4 == s_q.half
      |=> s_q.dn4)
    else $error("lag counter did not turn down at half cycle");
  a_pins_parked: assert property (
    !run && !$past(run) && $stable(s_q.ctrl) |-> pa_w == 3'h0 && aa_w == 3'h0)
    else $error("stopped pins not inactive");
  a_toggle_step: assert property (
    run && s_q.ctrl[`TCP_C_START] && s_q.ctrl[`TCP_C_TOG] && (pk || tr)
      |=> s_q.pwm.tog != $past(s_q.pwm.tog))
    else $error("toggle pin did not invert");
  a_adc_on_trough: assert property (
    s_q.pwm.adc |-> $past(tr) && s_q.pwm.trough)
    else $error("converter trigger outside trough");

  c_peak_seen:  cover property (pk);
  c_trough_adc: cover property (tr ##1 s_q.pwm.adc);
  c_duty_move:  cover property (pk && s_q.pend);
  c_toggle:     cover property (s_q.pwm.tog && run);
endmodule

// ### sim/tb_top.sv
// Purpose: Self-checking bench of the three-phase PWM block
// Assumes: Zero-wait APB slave, counters step every clock
// Notes:   Dead 2, half 4, upper 6 give an eight-clock carrier
`timescale 1ns/10ps
`include "tcp_cfg.svh"
module tb_top;
  import tcp_pkg::*;
  logic         clk;
  logic         rst_b;
  tcp_apb_req_t req;
  tcp_apb_rsp_t rsp;
  tcp_pwm_t     pwm;
  logic         clr;
  logic [15:0]  ctl;
  logic [31:0]  rd;
  logic         err;
  logic [2:0]   po, pa, ao, aa;
  int           overlaps;
  int           gaps;
  int           n;
  int           miscompares = 0;
  int           checks = 0;
  int           cycles = 0;

  tcp_pwm i_dut (
    .clock_i (clk),
    .rst_b_i (rst_b),
    .apb_i   (req),
    .apb_o   (rsp),
    .pwm_o   (pwm)
  );
  tcp_gate_model i_gate (
    .clock_i    (clk),
    .clr_i      (clr),
    .pos_i      (pwm.pos),
    .anti_i     (pwm.anti),
    .plvl_i     (ctl[`TCP_C_PLVL]),
    .alvl_i     (ctl[`TCP_C_ALVL]),
    .overlaps_o (overlaps),
    .gaps_o     (gaps)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge clk);
    req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: {16'h0000, d}};
    @(posedge clk);
    req.penable <= 1'h1;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'h1 && k < 50);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (wr && a == `TCP_A_CTRL) ctl = d;
  endtask
  task automatic wait_ev(input logic trough);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((trough ? pwm.trough : pwm.peak) !== 1'h1 && n < 100);
  endtask
  // Two settling clocks first, since pins lag a control change
  task automatic sample();
    repeat (2) @(posedge clk);
    clr <= 1'h1;
    @(posedge clk);
    clr <= 1'h0;
    {po, ao} = 6'h00;
    {pa, aa} = 6'h3F;
    repeat (16) begin
      @(posedge clk);
      po = po | pwm.pos;
      pa = pa & pwm.pos;
      ao = ao | pwm.anti;
      aa = aa & pwm.anti;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    chk("pos_idle", 32'h7, 32'(pwm.pos));
    chk("anti_idle", 32'h7, 32'(pwm.anti));
    apb(1'h0, `TCP_A_UCMP, 16'h0000);
    chk("upper_rst", 32'h0000FFFF, rd);
    apb(1'h1, `TCP_A_DEAD, 16'h0002);
    apb(1'h0, `TCP_A_DEAD, 16'h0000);
    chk("dead_rw", 32'h2, rd);
    apb(1'h0, 8'h3C, 16'h0000);
    chk("unmapped_err", 32'h1, 32'(err));
  endtask
  task automatic t_setup_start();
    apb(1'h1, `TCP_A_HALF, 16'h0004);
    apb(1'h1, `TCP_A_HBUF, 16'h0004);
    apb(1'h1, `TCP_A_UCMP, 16'h0006);
    apb(1'h1, `TCP_A_UBUF, 16'h0006);
    apb(1'h1, `TCP_A_CMP1, 16'h0000);
    apb(1'h1, `TCP_A_CMP2, 16'h0003);
    apb(1'h1, `TCP_A_CMP3, 16'h0006);
    apb(1'h0, `TCP_A_HALF, 16'h0000);
    chk("half_rw", 32'h4, rd);
    apb(1'h1, `TCP_A_CTRL, 16'h0005);
    chk("tog_start", 32'h0, 32'(pwm.tog));
  endtask
  task automatic t_carrier();
    logic prev;
    int   t;
    wait_ev(1'h0);
    wait_ev(1'h0);
    chk("peak_period", 32'd8, 32'(n));
    wait_ev(1'h1);
    chk("peak_to_trough", 32'd4, 32'(n));
    wait_ev(1'h1);
    chk("trough_period", 32'd8, 32'(n));
    chk("adc_at_trough", 32'h1, 32'(pwm.adc));
    t = 0;
    prev = pwm.tog;
    repeat (32) begin
      @(posedge clk);
      if (pwm.tog !== prev) t++;
      prev = pwm.tog;
    end
    chk("toggles", 32'd8, 32'(t));
  endtask
  task automatic t_levels();
    sample();
    chk("pos_or", 32'h3, 32'(po));
    chk("pos_and", 32'h1, 32'(pa));
    chk("anti_or", 32'h6, 32'(ao));
    chk("anti_and", 32'h4, 32'(aa));
    chk("overlap", 32'h0, 32'(overlaps));
    chk("gap_seen", 32'h1, 32'(gaps > 0));
    apb(1'h1, `TCP_A_CTRL, 16'h000D);
    sample();
    chk("pos_or_hi", 32'h6, 32'(po));
    chk("anti_or_lo", 32'h6, 32'(ao));
    apb(1'h1, `TCP_A_CTRL, 16'h000F);
    sample();
    chk("byp_gaps", 32'h0, 32'(gaps));
    chk("byp_overlap", 32'h0, 32'(overlaps));
  endtask
  task automatic t_duty_update();
    apb(1'h1, `TCP_A_BUF1, 16'h0002);
    apb(1'h1, `TCP_A_BUF2, 16'h0004);
    wait_ev(1'h0);
    wait_ev(1'h0);
    apb(1'h0, `TCP_A_CMP1, 16'h0000);
    chk("cmp1_held", 32'h0, rd);
    wait_ev(1'h0);
    apb(1'h1, `TCP_A_BUF3, 16'h0005);
    apb(1'h0, `TCP_A_STAT, 16'h0000);
    chk("pending", 32'h1, 32'(rd[4]));
    chk("peak_flag", 32'h1, 32'(rd[0]));
    wait_ev(1'h0);
    apb(1'h0, `TCP_A_CMP1, 16'h0000);
    chk("cmp1_new", 32'h2, rd);
    apb(1'h0, `TCP_A_CMP2, 16'h0000);
    chk("cmp2_new", 32'h4, rd);
    apb(1'h0, `TCP_A_CMP3, 16'h0000);
    chk("cmp3_new", 32'h5, rd);
    // Direct compare writes while running are software misuse
    apb(1'h1, `TCP_A_CMP1, 16'h0001);
    apb(1'h0, `TCP_A_CMP1, 16'h0000);
    chk("cmp1_direct", 32'h2, rd);
  endtask
  task automatic t_half_update();
    apb(1'h1, `TCP_A_HBUF, 16'h0005);
    apb(1'h1, `TCP_A_UBUF, 16'h0007);
    wait_ev(1'h0);
    apb(1'h0, `TCP_A_HALF, 16'h0000);
    chk("half_new", 32'h5, rd);
    apb(1'h0, `TCP_A_UCMP, 16'h0000);
    chk("upper_new", 32'h7, rd);
    wait_ev(1'h0);
    wait_ev(1'h0);
    chk("new_period", 32'd10, 32'(n));
    wait_ev(1'h1);
    chk("new_trough", 32'd5, 32'(n));
    apb(1'h1, `TCP_A_CTRL, 16'h0000);
    // Mode drops one edge later, the pins one edge after that
    repeat (3) @(posedge clk);
    chk("pos_stop", 32'h7, 32'(pwm.pos));
  endtask

  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  initial begin
    clk = 1'h0;
    rst_b = 1'h0;
    req = '0;
    clr = 1'h1;
    ctl = 16'h0000;
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    clr <= 1'h0;
    t_reset_values();
    t_setup_start();
    t_carrier();
    t_levels();
    t_duty_update();
    t_half_update();
    report_and_stop();
  end
  always #12.5 clk = ~clk;
  // Whole run needs well under a thousand clocks
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end
endmodule

// ### sim/tcp_gate_model.sv
// Purpose: Gate driver stand-in on the six phase lines
// Assumes: Active levels follow the bench copy of the control bits
// Notes:   Counts cycles with a leg pair both on, and with both off
`timescale 1ns/10ps
module tcp_gate_model (
  input  wire logic       clock_i,
  input  wire logic       clr_i,
  input  wire logic [2:0] pos_i,
  input  wire logic [2:0] anti_i,
  input  wire logic       plvl_i,
  input  wire logic       alvl_i,
  output int              overlaps_o,
  output int              gaps_o
);
  logic [2:0] pon;
  logic [2:0] aon;
  assign pon = plvl_i ? pos_i : ~pos_i;
  assign aon = alvl_i ? anti_i : ~anti_i;
  // Both legs on would short the supply, so every such cycle counts
  always @(posedge clock_i) begin
    if (clr_i) begin
      overlaps_o <= 0;
      gaps_o     <= 0;
    end else begin
      if ((pon & aon) !== 3'h0) overlaps_o <= overlaps_o + 1;
      if ((~pon & ~aon) !== 3'h0) gaps_o <= gaps_o + 1;
    end
  end
endmodule
